// *** hdl/gpio_ports.sv ***
// Ports A and B with direction, read-only port C, and port A function select
//
// The implementer's own choice: the plain strobed port.
`include "gpio_defs.svh"

module gpio_ports (
    // =========================================
    // Clock and reset
    input  logic                 core_clk,
    input  logic                 rst_n,
    // =========================================
    // Register port
    input  gpio_pkg::reg_req_t   bus_req,
    output logic [15:0]          rd_data,
    // =========================================
    // Port A pins and peripherals
    input  logic [15:0]          pa_pin_in,
    output gpio_pkg::pin_drive_t pa_drive,
    input  gpio_pkg::pa_alt_t    pa_alt,
    output logic [15:0]          pa_level,
    output logic [31:0]          pa_mode,
    // =========================================
    // Port B pins and peripherals
    input  logic [15:0]          pb_pin_in,
    input  logic [15:0]          pb_gpio,
    input  logic [15:0]          pb_tp,
    input  gpio_pkg::pin_drive_t pb_alt,
    output gpio_pkg::pin_drive_t pb_drive,
    output logic [15:0]          pb_level,
    // =========================================
    // Port C pins
    input  logic [7:0]           pc_pin_in,
    input  logic [7:0]           pc_analog
);

    // =========================================
    // Reset state
    // =========================================

    // Control registers at their defaults, pins released
    localparam gpio_pkg::gpio_state_t ST_RST = '{
        pa_fn_hi : `PA_FN_HI_RST,
        pa_fn_lo : `PA_FN_LO_RST,
        pa_mode  : `PA_MODE_RST,
        default  : '0
    };

    // =========================================
    // Signals
    // =========================================

    gpio_pkg::gpio_state_t s_reg;        // Registered state
    gpio_pkg::gpio_state_t s_next;       // Next state

    logic [39:0]           pin_sync_q;   // Synchronised pins
    logic [15:0]           pa_sync;      // Port A levels
    logic [15:0]           pb_sync;      // Port B levels
    logic [7:0]            pc_sync;      // Port C levels

    logic [15:0]           pa_rt_out;    // Routed port A data
    logic [15:0]           pa_rt_oe;     // Routed port A enable

    logic [15:0]           pa_rd_val;    // Port A read value
    logic [15:0]           pb_rd_val;    // Port B read value
    logic [15:0]           pc_rd_val;    // Port C read value

    // =========================================
    // Pin synchronisers
    // =========================================

    // Pins change with no regard to core_clk
    pin_sync #(
        .W (40)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      ({pa_pin_in, pb_pin_in, pc_pin_in}),
        .dout     (pin_sync_q)
    );

    // Split the synchronised word per port
    assign pa_sync = pin_sync_q[39:24];
    assign pb_sync = pin_sync_q[23:8];
    assign pc_sync = pin_sync_q[7:0];

    // =========================================
    // Port A pin routing
    // =========================================

    // Reserved-code maps, one bit per pin; indexed so each router
    // gets exactly one bit instead of a truncated shifted word
    localparam logic [15:0] RSV2_PINS = `PA_RSV_C2;
    localparam logic [15:0] RSV3_PINS = `PA_RSV_C3;

    // One router per pin; reserved codes per pin
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_pa
            pa_pin_route #(
                .RSV2 (RSV2_PINS[gi]),
                .RSV3 (RSV3_PINS[gi])
            ) u_route (
                .mode     (s_reg.pa_mode[gi*2 +: 2]),
                .gpio_out (s_reg.pa_data[gi]),
                .gpio_dir (s_reg.pa_dir[gi]),
                .alt_out  (pa_alt.out[gi]),
                .alt_oe   (pa_alt.oe[gi]),
                .pin_out  (pa_rt_out[gi]),
                .pin_oe   (pa_rt_oe[gi])
            );
        end
    endgenerate

    // =========================================
    // Read values
    // =========================================

    // Input pins show the pin, outputs the register
    assign pa_rd_val = (s_reg.pa_dir & s_reg.pa_data) |
                       (~s_reg.pa_dir & pa_sync);

    // Same choice on port B, pattern pins included
    assign pb_rd_val = (s_reg.pb_dir & s_reg.pb_data) |
                       (~s_reg.pb_dir & pb_sync);

    // Analog pins read as one; upper byte reads zero
    assign pc_rd_val = {8'h00, pc_sync | pc_analog};

    // =========================================
    // Next state
    // =========================================

    // Register writes, read data and pin drive
    always_comb
    begin
        s_next = s_reg;

        // -------------------------------------
        // Register writes
        // -------------------------------------
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                // Stored whatever the direction
                `OFS_PA_DATA:
                begin
                    s_next.pa_data = bus_req.wdata;
                end
                // Pattern pins keep their old bits
                `OFS_PB_DATA:
                begin
                    s_next.pb_data = (s_reg.pb_data & pb_tp) |
                                     (bus_req.wdata & ~pb_tp);
                end
                // One direction bit per pin
                `OFS_PA_DIR:
                begin
                    s_next.pa_dir = bus_req.wdata;
                end
                `OFS_PB_DIR:
                begin
                    s_next.pb_dir = bus_req.wdata;
                end
                // Reserved bit 1 stays at one
                `OFS_PA_FN_HI:
                begin
                    s_next.pa_fn_hi = (bus_req.wdata & `PA_FN_HI_WMASK) |
                                      ~`PA_FN_HI_WMASK;
                end
                // Odd upper bits stay at one
                `OFS_PA_FN_LO:
                begin
                    s_next.pa_fn_lo = (bus_req.wdata & `PA_FN_LO_WMASK) |
                                      ~`PA_FN_LO_WMASK;
                end
                // Port C and unmapped: ignored
                default:
                begin
                    s_next.pa_data = s_reg.pa_data;
                end
            endcase
        end

        // -------------------------------------
        // Register reads
        // -------------------------------------
        // Data stands one cycle, zero otherwise
        s_next.rd_data = '0;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                // Pin or register, per direction bit
                `OFS_PA_DATA:
                begin
                    s_next.rd_data = pa_rd_val;
                end
                // Pattern pins read the same way
                `OFS_PB_DATA:
                begin
                    s_next.rd_data = pb_rd_val;
                end
                // Direction registers read back as stored
                `OFS_PA_DIR:
                begin
                    s_next.rd_data = s_reg.pa_dir;
                end
                `OFS_PB_DIR:
                begin
                    s_next.rd_data = s_reg.pb_dir;
                end
                // Reserved bits are already held at one
                `OFS_PA_FN_HI:
                begin
                    s_next.rd_data = s_reg.pa_fn_hi;
                end
                `OFS_PA_FN_LO:
                begin
                    s_next.rd_data = s_reg.pa_fn_lo;
                end
                // Read-only port, analog pins forced high
                `OFS_PC_DATA:
                begin
                    s_next.rd_data = pc_rd_val;
                end
                // Unmapped reads return zero; the bus never waits
                default:
                begin
                    s_next.rd_data = '0;
                end
            endcase
        end

        // -------------------------------------
        // Port A function codes, two bits per pin
        // -------------------------------------
        // Pins 15..9 use two-bit fields as laid out
        // Pin 8 and pins 7..4 have a single bit
        // Pins 3..0 use two-bit fields
        s_next.pa_mode = {
            s_reg.pa_fn_hi[`PA_HI_2BIT],
            1'b0, s_reg.pa_fn_hi[`PA8_FN_BIT],
            1'b0, s_reg.pa_fn_lo[`PA7_FN_BIT],
            1'b0, s_reg.pa_fn_lo[`PA6_FN_BIT],
            1'b0, s_reg.pa_fn_lo[`PA5_FN_BIT],
            1'b0, s_reg.pa_fn_lo[`PA4_FN_BIT],
            s_reg.pa_fn_lo[`PA_LO_2BIT]
        };

        // -------------------------------------
        // Pin drive, one edge after a data or direction write, two after a function code write
        // -------------------------------------
        // Port A through the per-pin routers
        s_next.pa_drv.out = pa_rt_out;
        s_next.pa_drv.oe  = pa_rt_oe;

        // Port B: GPIO pins follow the register,
        // peripheral pins take the peripheral drive
        s_next.pb_drv.out = (pb_gpio & s_reg.pb_data) |
                            (~pb_gpio & pb_alt.out);
        s_next.pb_drv.oe  = (pb_gpio & s_reg.pb_dir) |
                            (~pb_gpio & pb_alt.oe);

        // -------------------------------------
        // Levels handed to the peripherals
        // -------------------------------------
        s_next.pa_level = pa_sync;
        s_next.pb_level = pb_sync;
    end

    // =========================================
    // State register
    // =========================================

    // Synchronous reset to the documented defaults
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            s_reg <= ST_RST;
        else
            s_reg <= s_next;
    end

    // =========================================
    // Outputs, straight from the state register
    // =========================================

    // Read data, valid only the cycle after the strobe
    assign rd_data  = s_reg.rd_data;
    // Pin drive, no glitches from the decode logic
    assign pa_drive = s_reg.pa_drv;
    assign pb_drive = s_reg.pb_drv;
    // Synchronised levels for the peripheral inputs
    assign pa_level = s_reg.pa_level;
    assign pb_level = s_reg.pb_level;
    // Stored function codes, reserved codes not folded
    assign pa_mode  = s_reg.pa_mode;

endmodule : gpio_ports

// *** hdl/gpio_defs.svh ***
// Offsets, reset values, field positions and widths of the port block
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

// Bus widths
`define ADDR_W 27
`define DATA_W 16

// Register offsets
`define OFS_PA_DATA    27'h5FFFFC0
`define OFS_PB_DATA    27'h5FFFFC2
`define OFS_PA_DIR     27'h5FFFFC4
`define OFS_PB_DIR     27'h5FFFFC6
`define OFS_PA_FN_HI   27'h5FFFFC8
`define OFS_PA_FN_LO   27'h5FFFFCA
`define OFS_PC_DATA    27'h5FFFFD0

// Reset values
`define PA_FN_HI_RST   16'h3302
`define PA_FN_LO_RST   16'hFF95
`define PA_MODE_RST    32'h33005595

// Writable bits; the others read as one
`define PA_FN_HI_WMASK 16'hFFFD
`define PA_FN_LO_WMASK 16'h55FF

// Field positions inside the function registers
`define PA_HI_2BIT     15:2
`define PA8_FN_BIT     0
`define PA7_FN_BIT     14
`define PA6_FN_BIT     12
`define PA5_FN_BIT     10
`define PA4_FN_BIT     8
`define PA_LO_2BIT     7:0

// Pins on which a code is reserved
`define PA_RSV_C2      16'hC000
`define PA_RSV_C3      16'h0C0F

`endif

// *** hdl/gpio_pkg.sv ***
// Types shared by the port block modules
package gpio_pkg;
`include "gpio_defs.svh"

    // Register port request
    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [`ADDR_W-1:0]  addr;
        logic [`DATA_W-1:0]  wdata;
    } reg_req_t;

    // Drive of one 16-pin port
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
    } pin_drive_t;

    // Peripheral drive per port A pin, codes 1..3
    typedef struct packed {
        logic [15:0][2:0] out;
        logic [15:0][2:0] oe;
    } pa_alt_t;

    // Pin function code
    typedef enum logic [1:0] {
        FN_GPIO = 2'b00,
        FN_ALT1 = 2'b01,
        FN_ALT2 = 2'b10,
        FN_ALT3 = 2'b11
    } pin_fn_t;

    // Whole state of the port block
    typedef struct packed {
        logic [15:0] pa_data;
        logic [15:0] pb_data;
        logic [15:0] pa_dir;
        logic [15:0] pb_dir;
        logic [15:0] pa_fn_hi;
        logic [15:0] pa_fn_lo;
        logic [15:0] rd_data;
        pin_drive_t  pa_drv;
        pin_drive_t  pb_drv;
        logic [15:0] pa_level;
        logic [15:0] pb_level;
        logic [31:0] pa_mode;
    } gpio_state_t;

endpackage : gpio_pkg

// *** hdl/pin_sync.sv ***
// Two-stage synchroniser for asynchronous pin levels
module pin_sync #(
    parameter int W = 8
) (
    input  logic         core_clk,
    input  logic         rst_n,
    input  logic [W-1:0] din,
    output logic [W-1:0] dout
);

    // Both stages as one state word
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    // First stage feeds only the second
    always_comb
    begin
        s_next        = s_reg;
        s_next.meta   = din;
        s_next.stable = s_reg.meta;
    end

    // Synchronous reset clears both stages
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign dout = s_reg.stable;

endmodule : pin_sync

// *** hdl/pa_pin_route.sv ***
// Routing of one port A pin between GPIO and its peripherals
module pa_pin_route #(
    parameter logic RSV2 = 1'b0,
    parameter logic RSV3 = 1'b0
) (
    input  logic [1:0] mode,
    input  logic       gpio_out,
    input  logic       gpio_dir,
    input  logic [2:0] alt_out,
    input  logic [2:0] alt_oe,
    output logic       pin_out,
    output logic       pin_oe
);

    gpio_pkg::pin_fn_t fn;

    // Decode the function and pick the driver
    always_comb
    begin
        fn = gpio_pkg::pin_fn_t'(mode);
        // Reserved codes fall back to plain GPIO
        if ((fn == gpio_pkg::FN_ALT2 && RSV2) ||
            (fn == gpio_pkg::FN_ALT3 && RSV3))
            fn = gpio_pkg::FN_GPIO;
        unique case (fn)
            gpio_pkg::FN_GPIO:
            begin
                // Output only when direction is 1
                pin_out = gpio_out;
                pin_oe  = gpio_dir;
            end
            gpio_pkg::FN_ALT1:
            begin
                pin_out = alt_out[0];
                pin_oe  = alt_oe[0];
            end
            gpio_pkg::FN_ALT2:
            begin
                pin_out = alt_out[1];
                pin_oe  = alt_oe[1];
            end
            gpio_pkg::FN_ALT3:
            begin
                pin_out = alt_out[2];
                pin_oe  = alt_oe[2];
            end
        endcase
    end

endmodule : pa_pin_route

// *** dv/pin_world.sv ***
// Model of the package pins and the peripherals that share them
module pin_world (
    input  logic                 alt_on,
    input  logic [15:0]          ext_a,
    input  logic [15:0]          ext_b,
    input  gpio_pkg::pin_drive_t pa_drive,
    input  gpio_pkg::pin_drive_t pb_drive,
    output gpio_pkg::pa_alt_t    pa_alt,
    output gpio_pkg::pin_drive_t pb_alt,
    output logic [15:0]          pa_pin_in,
    output logic [15:0]          pb_pin_in
);
    // =====
    // Peripherals drive a fixed pattern only while enabled
    assign pa_alt.out = {16{3'b101}};
    assign pa_alt.oe  = {48{alt_on}};
    assign pb_alt.out = 16'hC3C3;
    assign pb_alt.oe  = {16{alt_on}};
    // A released pin shows the outside level, never the last driven one
    assign pa_pin_in = (pa_drive.oe & pa_drive.out) | (~pa_drive.oe & ext_a);
    assign pb_pin_in = (pb_drive.oe & pb_drive.out) | (~pb_drive.oe & ext_b);
endmodule : pin_world

// *** dv/gpio_ports_sva.sv ***
// Checker of register and pin timing of the port block
`include "gpio_defs.svh"
module gpio_ports_sva (
    input logic                 core_clk,
    input logic                 rst_n,
    input gpio_pkg::reg_req_t   bus_req,
    input logic [15:0]          rd_data,
    input logic [15:0]          pa_pin_in,
    input gpio_pkg::pin_drive_t pa_drive,
    input gpio_pkg::pa_alt_t    pa_alt,
    input logic [15:0]          pa_level,
    input logic [31:0]          pa_mode,
    input logic [15:0]          pb_gpio,
    input gpio_pkg::pin_drive_t pb_alt,
    input gpio_pkg::pin_drive_t pb_drive,
    input logic [7:0]           pc_analog
);
    // =====
    // One clock domain for all checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_rd_idle: assert property (!$past(bus_req.rd) |-> rd_data == 16'h0000)
        else $error("read data outside its slot");
    chk_mode_reset: assert property ($rose(rst_n) |-> pa_mode == `PA_MODE_RST)
        else $error("bad function codes after reset");
    // Back-to-back write then read must return the new value
    chk_dir_back: assert property ((bus_req.wr && bus_req.addr == `OFS_PA_DIR) ##1
        (bus_req.rd && bus_req.addr == `OFS_PA_DIR) |=> rd_data == $past(bus_req.wdata, 2))
        else $error("direction not read back");
    chk_pc_read: assert property (bus_req.rd && bus_req.addr == `OFS_PC_DATA |=>
        rd_data[15:8] == 8'h00 && (rd_data[7:0] & $past(pc_analog)) == $past(pc_analog))
        else $error("bad port C read");
    chk_hi_ones: assert property (bus_req.rd && bus_req.addr == `OFS_PA_FN_HI |=> rd_data[1])
        else $error("reserved high bit not one");
    chk_lo_ones: assert property (bus_req.rd && bus_req.addr == `OFS_PA_FN_LO |=>
        (rd_data | `PA_FN_LO_WMASK) == 16'hFFFF)
        else $error("reserved low bits not one");
    // Pin 14 in code 3 follows the acknowledge source one edge later
    chk_route_dack: assert property ($past(rst_n) && $stable(pa_mode) && pa_mode[29:28] == 2'b11 |->
        pa_drive.oe[14] == $past(pa_alt.oe[14][2]) && pa_drive.out[14] == $past(pa_alt.out[14][2]))
        else $error("pin 14 not routed");
    chk_pb_periph: assert property ($past(rst_n) |->
        ((pb_drive.oe ^ $past(pb_alt.oe)) & ~$past(pb_gpio)) == 16'h0000)
        else $error("port B peripheral drive wrong");
    // Three edges of synchroniser and output register
    chk_level_sync: assert property ($past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) |->
        pa_level == $past(pa_pin_in, 3))
        else $error("port A level delay wrong");
endmodule : gpio_ports_sva

bind gpio_ports gpio_ports_sva i_gpio_ports_sva (.core_clk, .rst_n, .bus_req, .rd_data, .pa_pin_in,
    .pa_drive, .pa_alt, .pa_level, .pa_mode, .pb_gpio, .pb_alt, .pb_drive, .pc_analog);

// *** dv/tb_gpio_ports.sv ***
// Self-checking bench of the port block
`include "gpio_defs.svh"
module tb_gpio_ports;
    timeunit 1ns;
    timeprecision 1ps;
    // =====
    // Signals
    logic                 core_clk = 1'b0;
    logic                 rst_n = 1'b0;
    gpio_pkg::reg_req_t   bus_req = '0;
    logic [15:0]          pb_gpio = 16'h0000, pb_tp = 16'h0000, ext_a = 16'h0000, ext_b = 16'h0000;
    logic [7:0]           pc_pin_in = 8'h3C, pc_analog = 8'h81;
    logic                 alt_on = 1'b0;
    logic [15:0]          rd_data, pa_pin_in, pb_pin_in, pa_level, pb_level, eoe;
    logic [31:0]          pa_mode, m;
    logic [1:0]           c;
    gpio_pkg::pin_drive_t pa_drive, pb_drive, pb_alt;
    gpio_pkg::pa_alt_t    pa_alt;
    int                   fails = 0, n_compared = 0, cycles = 0;
    // Write, then read back at once
    typedef struct packed { logic [26:0] a; logic [15:0] w; logic [15:0] r; } row_t;
    row_t rows [8] = '{
        '{`OFS_PA_DIR, 16'hA5A5, 16'hA5A5},
        '{`OFS_PB_DIR, 16'h5A5A, 16'h5A5A},
        '{`OFS_PA_FN_HI, 16'h0000, 16'h0002},
        '{`OFS_PA_FN_LO, 16'h0000, 16'hAA00},
        '{`OFS_PA_FN_HI, 16'h5E95, 16'h5E97},
        '{`OFS_PA_FN_LO, 16'h0026, 16'hAA26},
        '{`OFS_PC_DATA, 16'hFFFF, 16'h00BD},
        '{27'h5FFFFCC, 16'h1234, 16'h0000}};
    always #4 core_clk = ~core_clk;
    gpio_ports i_gpio_ports (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
        .pa_pin_in(pa_pin_in), .pa_drive(pa_drive), .pa_alt(pa_alt), .pa_level(pa_level), .pa_mode(pa_mode),
        .pb_pin_in(pb_pin_in), .pb_gpio(pb_gpio), .pb_tp(pb_tp), .pb_alt(pb_alt), .pb_drive(pb_drive),
        .pb_level(pb_level), .pc_pin_in(pc_pin_in), .pc_analog(pc_analog));
    pin_world i_pin_world (.alt_on(alt_on), .ext_a(ext_a), .ext_b(ext_b), .pa_drive(pa_drive),
        .pb_drive(pb_drive), .pa_alt(pa_alt), .pb_alt(pb_alt), .pa_pin_in(pa_pin_in), .pb_pin_in(pb_pin_in));
    // =====
    // Tasks
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus_wr(input logic [26:0] a, input logic [15:0] d);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    endtask : bus_wr
    // Releases the strobe, then lets the pins settle
    task automatic idle(input int n);
        @(posedge core_clk);
        bus_req <= '0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask : idle
    task automatic rd_chk(input logic [26:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge core_clk);
        bus_req <= '0;
        #1 check(rd_data, exp);
    endtask : rd_chk
    // Code per pin as stored; with eff set, reserved codes fall back to GPIO
    function automatic logic [31:0] mode_of(input logic [1:0] k, input logic eff);
        logic [31:0] r;
        for (int i = 0; i < 16; i++)
        begin
            r[2*i+:2] = (i >= 4 && i <= 8) ? {1'b0, k[0]} : k;
            if (eff && ((k == 2'b10 && i >= 14) || (k == 2'b11 && (i == 10 || i == 11 || i <= 3))))
                r[2*i+:2] = 2'b00;
        end
        return r;
    endfunction : mode_of
    // Hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            print_verdict();
        end
    end
    // =====
    // Main sequence
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            bus_wr(rows[i].a, rows[i].w);
            rd_chk(rows[i].a, rows[i].r);
        end
        $display("register table done");
        bus_wr(`OFS_PA_FN_HI, 16'h0000);
        ext_a <= 16'hABCD;
        bus_wr(`OFS_PA_FN_LO, 16'h0000);
        bus_wr(`OFS_PA_DIR, 16'h00FF);
        bus_wr(`OFS_PA_DATA, 16'h1234);
        idle(4);
        check(pa_drive.oe, 16'h00FF);
        check(pa_drive.out & pa_drive.oe, 16'h0034);
        rd_chk(`OFS_PA_DATA, 16'hAB34);
        $display("port A data done");
        bus_wr(`OFS_PA_DIR, 16'h0000);
        alt_on <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            c = k[1:0];
            bus_wr(`OFS_PA_FN_HI, {c, c, c, c, c, c, c, 1'b1, c[0]});
            bus_wr(`OFS_PA_FN_LO, {1'b1, c[0], 1'b1, c[0], 1'b1, c[0], 1'b1, c[0], c, c, c, c});
            idle(3);
            m = mode_of(c, 1'b1);
            for (int i = 0; i < 16; i++)
                eoe[i] = m[2*i+:2] != 2'b00;
            check(pa_mode, mode_of(c, 1'b0));
            check(pa_drive.oe, eoe);
            check(pa_drive.out & pa_drive.oe, eoe & (16'h01F0 | {16{~c[1] | c[0]}}));
        end
        $display("function codes done");
        bus_wr(`OFS_PA_DATA, 16'h0000);
        alt_on <= 1'b0;
        // Mid-run reset on the edge; three edges flush the synchronisers
        @(posedge core_clk);
        bus_req <= '0;
        rst_n   <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_chk(`OFS_PA_FN_HI, `PA_FN_HI_RST);
        rd_chk(`OFS_PA_FN_LO, `PA_FN_LO_RST);
        rd_chk(`OFS_PA_DIR, 16'h0000);
        rd_chk(`OFS_PB_DIR, 16'h0000);
        rd_chk(`OFS_PA_DATA, 16'hABCD);
        $display("second reset done");
        bus_wr(`OFS_PB_DIR, 16'hFFFF);
        pb_gpio <= 16'h00FF;
        pb_tp <= 16'hF000;
        ext_b <= 16'h5A5A;
        bus_wr(`OFS_PB_DATA, 16'hFFFF);
        idle(4);
        check(pb_drive.out & pb_drive.oe & 16'h00FF, 16'h00FF);
        rd_chk(`OFS_PB_DATA, 16'h0FFF);
        bus_wr(`OFS_PB_DIR, 16'h0F0F);
        idle(4);
        check(pb_level, 16'h5A5F);
        rd_chk(`OFS_PB_DATA, 16'h5F5F);
        $display("port B done");
        print_verdict();
    end
endmodule : tb_gpio_ports
